// ### bench/pcicap_pci_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcicap_pci_model (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        req_i,
  input  wire logic        no_idsel_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  lat_i,
  output var  logic        done_o,
  output var  logic        mabort_o,
  output var  logic [31:0] rdata_o
);
  logic [1:0] cnt_ff;
  wire        fin = req_i && !done_o && cnt_ff == lat_i;
  // Answer after lat_i waits; data toggles when not driven
  always @(posedge clk_i) begin
    cnt_ff <= (srst_i || !req_i || done_o) ? 2'h0 : cnt_ff + 2'h1;
    done_o <= !srst_i && fin;
    // no target claims an unselected cycle
    mabort_o <= fin && no_idsel_i;
    rdata_o <= srst_i ? 32'h0 : fin ? addr_i ^ 32'hA5A5_0000 : ~rdata_o;
  end
endmodule
`default_nettype wire

// ### bench/pcicap_props.sv
`timescale 1ns/1ps
`default_nettype none
module pcicap_props (
  // Clock, reset, host side
  input wire logic        CORE_CLK_I,
  input wire logic        SRST_I,
  input wire logic [15:0] HOST_ADDR_I,
  input wire logic [3:0]  HOST_BE_I,
  input wire logic        HOST_ACK_O,
  // PCI side, port view
  input wire logic        PCI_REQ_O,
  input wire logic [3:0]  PCI_CMD_O,
  input wire logic [31:0] PCI_ADDR_O,
  input wire logic        PCI_NO_IDSEL_O,
  input wire logic        PCI_DONE_I,
  input wire logic [31:0] CFG_ADDR_PORT_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  // Port fields seen during a config cycle
  wire [4:0] dev = CFG_ADDR_PORT_O[15:11];
  wire       cfg = PCI_REQ_O && PCI_CMD_O[3];
  wire       t0  = cfg && CFG_ADDR_PORT_O[23:16] == 8'h00;
  AST_PORT_RST: assert property (
    $fell(SRST_I) |-> CFG_ADDR_PORT_O == 32'h0000_0000)
    else $error("port not clear");
  AST_PORT_RSV: assert property (
    (CFG_ADDR_PORT_O & 32'h7F00_0003) == 32'h0000_0000)
    else $error("reserved port bit set");
  AST_PORT_UPD: assert property (
    !$stable(CFG_ADDR_PORT_O) |-> HOST_ACK_O &&
    $past(HOST_ADDR_I) == 16'h0CF8 && $past(HOST_BE_I) == 4'hF)
    else $error("port changed without dword write");
  AST_PREQ_HOLD: assert property (
    PCI_REQ_O && !PCI_DONE_I |=> PCI_REQ_O &&
    $stable(PCI_ADDR_O) && $stable(PCI_CMD_O))
    else $error("pci req moved");
  AST_PREQ_END: assert property (
    PCI_REQ_O && PCI_DONE_I |=> !PCI_REQ_O && HOST_ACK_O ##1 !HOST_ACK_O)
    else $error("pci end");
  AST_LOCAL: assert property (
    cfg |-> CFG_ADDR_PORT_O[31] && CFG_ADDR_PORT_O[23:8] != 16'h0000)
    else $error("bad config cycle");
  AST_OFF_IO: assert property (
    PCI_REQ_O && !CFG_ADDR_PORT_O[31] |-> PCI_CMD_O[3:1] == 3'h1)
    else $error("disabled not io");
  AST_TYPE1: assert property (
    cfg && !t0 |-> PCI_ADDR_O == {8'h00, CFG_ADDR_PORT_O[23:2], 2'h1})
    else $error("type 1 addr");
  AST_T0_LOW: assert property (
    t0 |-> PCI_ADDR_O[10:2] == CFG_ADDR_PORT_O[10:2])
    else $error("type 0 low addr");
  AST_IDSEL: assert property (
    t0 && dev != 5'h00 && dev <= 5'h14 |-> !PCI_NO_IDSEL_O &&
    PCI_ADDR_O[31:11] == (21'h00_0001 << dev))
    else $error("idsel");
  AST_NOSEL: assert property (
    t0 && (dev == 5'h00 || dev > 5'h14) |-> PCI_NO_IDSEL_O &&
    PCI_ADDR_O[31:11] == 21'h00_0000)
    else $error("no idsel");
  // Main scenarios
  cover property (t0 && PCI_NO_IDSEL_O && PCI_DONE_I);
  cover property (cfg && !t0 && PCI_DONE_I);
  cover property (!$stable(CFG_ADDR_PORT_O));
endmodule
bind pcicap_top pcicap_props u_pcicap_props (.CORE_CLK_I(CORE_CLK_I),
  .SRST_I(SRST_I), .HOST_ADDR_I(HOST_ADDR_I), .HOST_BE_I(HOST_BE_I),
  .HOST_ACK_O(HOST_ACK_O), .PCI_REQ_O(PCI_REQ_O), .PCI_CMD_O(PCI_CMD_O),
  .PCI_ADDR_O(PCI_ADDR_O), .PCI_NO_IDSEL_O(PCI_NO_IDSEL_O),
  .PCI_DONE_I(PCI_DONE_I), .CFG_ADDR_PORT_O(CFG_ADDR_PORT_O));
`default_nettype wire

// ### bench/pcicap_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pcicap_top_bench;
  localparam [15:0] VC = 16'h5A3C; // Arbitrary value
  logic        clk, rst, req, wr, pv, ab;
  logic [1:0]  lat;
  logic [3:0]  be, pcmd, pbe;
  logic [15:0] ha;
  logic [31:0] wd, rd, pad, pwd, st, p, x;
  logic [31:0] loc [0:63];
  wire         ack, pr, nsel, done, mab;
  wire  [3:0]  cmd, pb;
  wire  [31:0] hrd, pa, pw, prd, cap;
  integer      err_count, n_checks, i;
  pcicap_top #(.VENDOR_CODE(VC)) u_pcicap_top (.CORE_CLK_I(clk),
    .SRST_I(rst), .HOST_REQ_I(req), .HOST_WR_I(wr), .HOST_ADDR_I(ha),
    .HOST_BE_I(be), .HOST_WDATA_I(wd), .HOST_ACK_O(ack),
    .HOST_RDATA_O(hrd), .PCI_REQ_O(pr), .PCI_CMD_O(cmd), .PCI_ADDR_O(pa),
    .PCI_BE_O(pb), .PCI_WDATA_O(pw), .PCI_NO_IDSEL_O(nsel),
    .PCI_DONE_I(done), .PCI_MABORT_I(mab), .PCI_RDATA_I(prd),
    .CFG_ADDR_PORT_O(cap));
  pcicap_pci_model u_pcicap_pci_model (.clk_i(clk), .srst_i(rst),
    .req_i(pr), .no_idsel_i(nsel), .addr_i(pa), .lat_i(lat),
    .done_o(done), .mabort_o(mab), .rdata_o(prd));
  // Clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  function [31:0] rnd;
    begin
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      rnd = st;
    end
  endfunction
  // Expected address phase for a port value
  function [31:0] ead(input logic [31:0] q);
    begin
      if (q[23:16] != 8'h00) ead = {8'h00, q[23:2], 2'h1};
      else if (q[15:11] == 5'h00 || q[15:11] > 5'h14) ead = q & 32'h0000_07FC;
      else ead = (32'h1 << (q[15:11] + 11)) | (q & 32'h0000_07FC);
    end
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // One host I/O cycle; notes the PCI request it caused
  task acc(input logic w, input logic [15:0] a, input logic [3:0] b,
           input logic [31:0] d);
    integer k;
    begin
      @(negedge clk);
      {req, wr, ha, be, wd, pv, k} = {1'b1, w, a, b, d, 1'b0, 32'sd0};
      while (ack !== 1'b1 && k < 20) begin
        @(posedge clk);
        #1;
        k = k + 1;
        if (pr === 1'b1 && !pv) begin
          {pv, pcmd, pbe} = {1'b1, cmd, pb};
          {pad, pwd} = {pa, pw};
        end
      end
      rd = hrd;
      if (ack !== 1'b1) begin
        chk(32'h0, 32'h1);
        wrap_up;
      end else begin
        @(negedge clk);
        req = 0;
      end
    end
  endtask
  initial begin
    {err_count, n_checks, st} = {32'sd0, 32'sd0, 32'h0000_74FA};
    {req, wr, ha, be, wd, lat, rst} = 0;
    rst = 1;
    // Count rising edges; a falling edge at time zero is a race
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk(cap, 32'h0);
    // Disabled window and narrow port writes go out as I/O
    acc(0, 16'h0CFC, 4'hF, 32'h0);
    chk({27'h0, pv, pcmd}, 32'h12);
    chk(pad, 32'h0000_0CFC);
    chk(rd, 32'hA5A5_0CFC);
    acc(1, 16'h0CF8, 4'h1, 32'hFFFF_FFFF);
    chk({27'h0, pv, pcmd}, 32'h13);
    chk({28'h0, pbe}, 32'h1);
    chk(cap, 32'h0);
    acc(1, 16'h0CF8, 4'hF, 32'hFFFF_FFFF);
    acc(0, 16'h0CF8, 4'hF, 32'h0);
    chk(rd, 32'h80FF_FFFC);
    // Last local dword, byte lanes
    acc(1, 16'h0CF8, 4'hF, 32'h8000_00FC);
    acc(1, 16'h0CFC, 4'hF, 32'hFFFF_FFFF);
    acc(1, 16'h0CFC, 4'h5, 32'h0);
    acc(0, 16'h0CFC, 4'hF, 32'h0);
    chk(rd, 32'hFF00_FF00);
    // Every device number, some buses, random latency
    for (i = 0; i < 34; i = i + 1) begin
      x = rnd();
      lat = x[31:30];
      p = {8'h80, (i % 4 == 3) ? x[23:16] | 8'h01 : 8'h00, i[4:0],
           i == 0 ? 3'h0 : x[10:8] | {2'h0, i[5]}, i == 0 ? 6'h0 : x[7:2],
           2'h0};
      acc(1, 16'h0CF8, 4'hF, p);
      chk(cap, p);
      x = rnd();
      acc(1, 16'h0CFC, 4'hF, x);
      if (p[23:8] == 16'h0) loc[p[7:2]] = p[7:2] == 0 ? {x[31:16], VC} : x;
      else chk(pwd, x);
      acc(0, 16'h0CFC, 4'hF, 32'h0);
      ab = p[23:16] == 0 && (p[15:11] == 0 || p[15:11] > 5'h14);
      if (p[23:8] == 16'h0) chk(rd, loc[p[7:2]]);
      else chk(pad, ead(p));
      if (p[23:8] != 16'h0)
        chk(rd, ab ? 32'hFFFF_FFFF : ead(p) ^ 32'hA5A5_0000);
      chk({27'h0, pv, pcmd & {4{pv}}},
          p[23:8] == 16'h0 ? 32'h0000_0000 : 32'h0000_001A);
    end
    // Second reset in mid-run
    rst = 1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk(cap, 32'h0);
    // Port reads back clear and the window is off again
    acc(0, 16'h0CF8, 4'hF, 32'h0);
    chk(rd, 32'h0);
    acc(0, 16'h0CFC, 4'hF, 32'h0);
    chk({27'h0, pv, pcmd}, 32'h12);
    wrap_up;
  end
endmodule
`default_nettype wire

// ### shared/pcicap_defs.vh
`ifndef PCICAP_DEFS_VH
`define PCICAP_DEFS_VH

// Host I/O locations
`define PCICAP_ADDR_PORT_IO   16'h0CF8
`define PCICAP_DATA_WIN_IO    16'h0CFC

// Address port field positions
`define PCICAP_EN_BIT         31
`define PCICAP_BUS_HI         23
`define PCICAP_BUS_LO         16
`define PCICAP_DEV_HI         15
`define PCICAP_DEV_LO         11
`define PCICAP_FUNC_HI        10
`define PCICAP_FUNC_LO        8
`define PCICAP_REG_HI         7
`define PCICAP_REG_LO         2

// Reset value and writable mask of the address port
`define PCICAP_ADDR_RESET     32'h0000_0000
`define PCICAP_ADDR_WMASK     32'h80FF_FFFC

// Highest device number with an IDSEL line
`define PCICAP_MAX_IDSEL_DEV  5'h14

// Type 1 marker on AD[1:0]
`define PCICAP_TYPE1_CODE     2'h1

// Local space: vendor code offset and size
`define PCICAP_VENDOR_OFS     6'h00
`define PCICAP_LOCAL_BYTES    256

// PCI command codes
`define PCICAP_CMD_IO_RD      4'h2
`define PCICAP_CMD_IO_WR      4'h3
`define PCICAP_CMD_CFG_RD     4'hA
`define PCICAP_CMD_CFG_WR     4'hB

`endif

// ### src/pcicap_idsel_dec.v
`timescale 1ns/1ps
`default_nettype none
`include "pcicap_defs.vh"

// Type 0 address: one-hot IDSEL on AD[31:11], function and register below
module pcicap_idsel_dec (
  // Address port contents
  input  wire [31:0] addr_port_i,
  // Address phase value
  output reg  [31:0] ad_o
);

  wire [4:0] dev = addr_port_i[`PCICAP_DEV_HI:`PCICAP_DEV_LO];

  // Device n from 1 drives AD line 11+n; none for device 0 or above the last
  always @* begin
    ad_o = 32'h0000_0000;
    ad_o[10:2] = addr_port_i[10:2];
    if ((dev != 5'h00) && (dev <= `PCICAP_MAX_IDSEL_DEV)) begin
      ad_o[5'd11 + dev] = 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### src/pcicap_local_space.v
`timescale 1ns/1ps
`default_nettype none
`include "pcicap_defs.vh"

// Bridge's own configuration space, dword addressed, byte writable
module pcicap_local_space #(
  parameter [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
  parameter        DWORDS      = `PCICAP_LOCAL_BYTES / 4
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        srst_i,
  // Access
  input  wire [5:0]  reg_i,
  input  wire        wr_i,
  input  wire [3:0]  be_i,
  input  wire [31:0] wdata_i,
  output wire [31:0] rdata_o
);

  // Flip-flop storage, one word per register number
  reg [31:0] mem_ff [0:DWORDS-1];
  integer    i;
  integer    b;

  // Byte-lane writes; low half of word zero never changes
  always @(posedge clk_i) begin
    if (srst_i) begin
      for (i = 0; i < DWORDS; i = i + 1) begin
        mem_ff[i] <= 32'h0000_0000;
      end
    end else if (wr_i) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (be_i[b] && !((reg_i == `PCICAP_VENDOR_OFS) && (b < 2))) begin
          mem_ff[reg_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
        end
      end
    end
  end

  assign rdata_o = (reg_i == `PCICAP_VENDOR_OFS) ?
                   {mem_ff[0][31:16], VENDOR_CODE} : mem_ff[reg_i];

endmodule
`default_nettype wire

// ### src/pcicap_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pcicap_defs.vh"

// Functional notes
// - Address port latches only on dword access
// - Byte/word address access passes to PCI
// - Port holds enable, bus, device, function, register
// - Translate data window only when enabled
// - One config access per window access
// - Only mechanism one, type 0 and 1
// - Bus0 dev0 func0 answered locally
// - Bus0 dev0 nonzero function: no IDSEL
// - Type 0 copies bits 10:2
// - Device number one-hot onto AD[31:11]
// - Device above twenty: no IDSEL
// - Type 1 copies 23:2, AD[1:0]=01
// - Register number on AD[7:2]
// - Function number on AD[10:8]
// - Local space is 256 bytes
// - Address port resets to zero
// - Vendor code fixed and read-only
// - Only host cycles reach local registers
module pcicap_top #(
  parameter [15:0] VENDOR_CODE = 16'h1234 // Arbitrary value
) (
  // Clock and reset
  input  wire        CORE_CLK_I,
  input  wire        SRST_I,
  // Host I/O request
  input  wire        HOST_REQ_I,
  input  wire        HOST_WR_I,
  input  wire [15:0] HOST_ADDR_I,
  input  wire [3:0]  HOST_BE_I,
  input  wire [31:0] HOST_WDATA_I,
  // Host answer
  output reg         HOST_ACK_O,
  output reg  [31:0] HOST_RDATA_O,
  // Outgoing PCI request
  output reg         PCI_REQ_O,
  output reg  [3:0]  PCI_CMD_O,
  output reg  [31:0] PCI_ADDR_O,
  output reg  [3:0]  PCI_BE_O,
  output reg  [31:0] PCI_WDATA_O,
  output reg         PCI_NO_IDSEL_O,
  // PCI completion
  input  wire        PCI_DONE_I,
  input  wire        PCI_MABORT_I,
  input  wire [31:0] PCI_RDATA_I,
  // Address port view
  output reg  [31:0] CFG_ADDR_PORT_O
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PCI  = 3'b010;
  localparam [2:0] ST_ACK  = 3'b100;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [31:0] addr_port_ff;
  reg  [31:0] nxt_addr_port;

  wire [31:0] type0_ad;
  wire [31:0] local_rdata;
  reg         local_wr;

  // Decode of the host request
  wire        full_dword = (HOST_BE_I == 4'hF);
  wire        hit_addr   = (HOST_ADDR_I == `PCICAP_ADDR_PORT_IO);
  // Window spans four byte addresses; lanes come from the enables
  wire        hit_data   = ((HOST_ADDR_I & 16'hFFFC) == `PCICAP_DATA_WIN_IO);
  wire        cfg_en     = addr_port_ff[`PCICAP_EN_BIT];
  wire [7:0]  bus_num    = addr_port_ff[`PCICAP_BUS_HI:`PCICAP_BUS_LO];
  wire [4:0]  dev_num    = addr_port_ff[`PCICAP_DEV_HI:`PCICAP_DEV_LO];
  wire [2:0]  func_num   = addr_port_ff[`PCICAP_FUNC_HI:`PCICAP_FUNC_LO];
  wire [5:0]  reg_num    = addr_port_ff[`PCICAP_REG_HI:`PCICAP_REG_LO];
  wire        is_local   = (bus_num == 8'h00) && (dev_num == 5'h00) &&
                           (func_num == 3'h0);
  wire        type0      = (bus_num == 8'h00);
  wire        no_idsel   = type0 && ((dev_num == 5'h00) ||
                           (dev_num > `PCICAP_MAX_IDSEL_DEV));
  wire        idle       = state_ff[0];
  wire        take       = idle && HOST_REQ_I;

  pcicap_idsel_dec u_idsel (
    .addr_port_i (addr_port_ff),
    .ad_o        (type0_ad)
  );

  pcicap_local_space #(
    .VENDOR_CODE (VENDOR_CODE)
  ) u_local (
    .clk_i   (CORE_CLK_I),
    .srst_i  (SRST_I),
    .reg_i   (reg_num),
    .wr_i    (local_wr),
    .be_i    (HOST_BE_I),
    .wdata_i (HOST_WDATA_I),
    .rdata_o (local_rdata)
  );

  // Address port next value
  always @* begin
    nxt_addr_port = addr_port_ff;
    if (take && HOST_WR_I && hit_addr && full_dword) begin
      nxt_addr_port = HOST_WDATA_I & `PCICAP_ADDR_WMASK;
    end
  end

  // Local write strobe, host side only
  always @* begin
    local_wr = 1'b0;
    if (take && HOST_WR_I && hit_data && cfg_en && is_local) begin
      local_wr = 1'b1;
    end
  end

  // Request sequencing
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (HOST_REQ_I) begin
          if ((hit_addr && full_dword) ||
              (hit_data && cfg_en && is_local)) begin
            nxt_state = ST_ACK;
          end else begin
            nxt_state = ST_PCI;
          end
        end
      end
      ST_PCI: begin
        if (PCI_DONE_I) begin
          nxt_state = ST_ACK;
        end
      end
      ST_ACK: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State and port registers
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_ff     <= ST_IDLE;
      addr_port_ff <= `PCICAP_ADDR_RESET;
    end else begin
      state_ff     <= nxt_state;
      addr_port_ff <= nxt_addr_port;
    end
  end

  // Outputs, all registered
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      HOST_ACK_O      <= 1'b0;
      HOST_RDATA_O    <= 32'h0000_0000;
      PCI_REQ_O       <= 1'b0;
      PCI_CMD_O       <= 4'h0;
      PCI_ADDR_O      <= 32'h0000_0000;
      PCI_BE_O        <= 4'h0;
      PCI_WDATA_O     <= 32'h0000_0000;
      PCI_NO_IDSEL_O  <= 1'b0;
      CFG_ADDR_PORT_O <= `PCICAP_ADDR_RESET;
    end else begin
      HOST_ACK_O      <= 1'b0;
      CFG_ADDR_PORT_O <= nxt_addr_port;
      if (take) begin
        PCI_BE_O       <= HOST_BE_I;
        PCI_WDATA_O    <= HOST_WDATA_I;
        PCI_NO_IDSEL_O <= 1'b0;
        HOST_RDATA_O   <= 32'h0000_0000;
        if (hit_addr && full_dword) begin
          // Port read back directly
          HOST_RDATA_O <= addr_port_ff;
        end else if (hit_data && cfg_en && is_local) begin
          HOST_RDATA_O <= local_rdata;
        end else if (hit_data && cfg_en) begin
          PCI_REQ_O <= 1'b1;
          PCI_CMD_O <= HOST_WR_I ? `PCICAP_CMD_CFG_WR : `PCICAP_CMD_CFG_RD;
          if (type0) begin
            PCI_NO_IDSEL_O <= no_idsel;
            PCI_ADDR_O <= type0_ad;
          end else begin
            PCI_ADDR_O <= {8'h00, addr_port_ff[23:2], `PCICAP_TYPE1_CODE};
          end
        end else begin
          PCI_REQ_O  <= 1'b1;
          PCI_CMD_O  <= HOST_WR_I ? `PCICAP_CMD_IO_WR : `PCICAP_CMD_IO_RD;
          PCI_ADDR_O <= {16'h0000, HOST_ADDR_I};
        end
      end else if (state_ff[1]) begin
        if (PCI_DONE_I) begin
          PCI_REQ_O <= 1'b0;
          // Master abort reads back all ones
          HOST_RDATA_O <= PCI_MABORT_I ? 32'hFFFF_FFFF : PCI_RDATA_I;
        end
      end
      if (nxt_state[2] && !state_ff[2]) begin
        HOST_ACK_O <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire
